// ### cca_counter_array.sv
// cca_counter_array: 16-bit time base with three capture/compare modules
// assumes: config and strobes come from core_clk logic; pins and oscillator are asynchronous
//
// How it works
// R1 - one 16-bit counter is the common time base of exactly three capture/compare modules.
// R2 - the counter ticks from one of six sources: sysclk/12, sysclk/4, timer 0 overflow, ext count input, sysclk, ext oscillator/8.
// R3 - each module runs in its own mode: capture, software timer, high-speed output, 8/16-bit pwm or frequency output.
// R4 - module 2 can also act as a watchdog besides its ordinary modes.
// R5 - after reset module 2 is in watchdog mode and enabled with no software action.
// R6 - each module's pin signal and the ext count input are ports for the pin crossbar.
// R7 - counter and modules freeze while the core is halted by the debugger.
// R8 - the counter advances by one per source event and wraps from its maximum to zero.
`timescale 1ns/1ps
module cca_counter_array #(
   parameter int SLOW_DIV = 12, // sysclk slow divider
   parameter int FAST_DIV = 4, // sysclk fast divider
   parameter int OSC_DIV = 8 // ext oscillator divider
) (
   input wire logic core_clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic counter_run, // time base enable
   input wire cca_pkg::cca_clksrc_e clk_sel, // time base source
   input wire logic timer0_ovf, // timer 0 overflow pulse
   input wire logic ext_count_input, // ext count pin, async
   input wire logic ext_osc_clk, // ext oscillator, async
   input wire logic debug_halt, // core halted, step or breakpoint
   input wire cca_pkg::cca_mod_cfg_s [cca_pkg::NUM_MOD-1:0] mod_cfg, // module setup
   input wire logic [cca_pkg::NUM_MOD-1:0] mod_in, // module pins, async
   input wire logic wd_kick, // reload watchdog pulse
   input wire logic wd_disable, // leave watchdog pulse
   input wire logic wd_enable, // enter watchdog pulse
   input wire logic [cca_pkg::CNT_W-1:0] wd_offset, // watchdog reload distance
   output logic [cca_pkg::CNT_W-1:0] count, // time base value
   output logic [cca_pkg::NUM_MOD-1:0] mod_out, // module pin outputs
   output logic [cca_pkg::NUM_MOD-1:0][cca_pkg::CNT_W-1:0] cap_val, // captured counts
   output logic [cca_pkg::NUM_MOD-1:0] mod_evt, // match or capture pulse
   output logic cnt_ovf, // counter wrap pulse
   output logic wd_active, // watchdog mode on
   output logic wd_reset // watchdog expiry pulse
);

   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   initial begin
      if (SLOW_DIV < 2 || SLOW_DIV > 16 || FAST_DIV < 2 || FAST_DIV > 16 ||
          OSC_DIV < 2 || OSC_DIV > 16) begin
         $error("cca_counter_array: dividers must lie in 2..16");
      end
   end

   localparam logic [3:0] SLOW_LAST = 4'(SLOW_DIV - 1);
   localparam logic [3:0] FAST_LAST = 4'(FAST_DIV - 1);
   localparam logic [3:0] OSC_LAST = 4'(OSC_DIV - 1);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] slow_div;
      logic [3:0] fast_div;
      logic [3:0] osc_div;
      logic [1:0] eci_sync;
      logic eci_prev;
      logic [1:0] osc_sync;
      logic osc_prev;
      logic [cca_pkg::NUM_MOD-1:0] in_sync1;
      logic [cca_pkg::NUM_MOD-1:0] in_sync2;
      logic [cca_pkg::NUM_MOD-1:0] in_prev;
      logic [cca_pkg::CNT_W-1:0] cnt;
      logic [cca_pkg::NUM_MOD-1:0] out;
      logic [cca_pkg::NUM_MOD-1:0][cca_pkg::CNT_W-1:0] cap;
      logic [cca_pkg::NUM_MOD-1:0][cca_pkg::BYTE_W-1:0] phase;
      logic [cca_pkg::NUM_MOD-1:0] evt;
      logic ovf;
      logic wd_en;
      logic [cca_pkg::CNT_W-1:0] wd_cmp;
      logic wd_rst;
   } cca_state_s;

   cca_state_s st_r;
   cca_state_s st_nxt;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] cca_div_step(input logic [3:0] cur, input logic [3:0] last);
      cca_div_step = (cur == last) ? cca_pkg::DIV_RST : 4'(cur + cca_pkg::DIV_ONE);
   endfunction : cca_div_step

   function automatic logic cca_edge(input logic cur, input logic prev,
                                     input logic rise, input logic fall);
      cca_edge = (rise && cur && !prev) || (fall && !cur && prev);
   endfunction : cca_edge

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic tick;
      logic run;
      logic hit;
      logic [cca_pkg::CNT_W-1:0] cnt_inc;
      tick = 1'b0;
      run = 1'b0;
      hit = 1'b0;
      cnt_inc = cca_pkg::CNT_RST;
      st_nxt = st_r;
      st_nxt.evt = '0;
      st_nxt.ovf = 1'b0;
      st_nxt.wd_rst = 1'b0;

      // synchronisers, first stage read only by the second
      st_nxt.eci_sync = {st_r.eci_sync[0], ext_count_input};
      st_nxt.eci_prev = st_r.eci_sync[1];
      st_nxt.osc_sync = {st_r.osc_sync[0], ext_osc_clk};
      st_nxt.osc_prev = st_r.osc_sync[1];
      st_nxt.in_sync1 = mod_in;
      st_nxt.in_sync2 = st_r.in_sync1;
      st_nxt.in_prev = st_r.in_sync2;

      run = !debug_halt; // R7
      if (run) begin
         st_nxt.slow_div = cca_div_step(st_r.slow_div, SLOW_LAST);
         st_nxt.fast_div = cca_div_step(st_r.fast_div, FAST_LAST);
         if (st_r.osc_sync[1] && !st_r.osc_prev) begin
            st_nxt.osc_div = cca_div_step(st_r.osc_div, OSC_LAST);
         end
      end

      // source select
      case (clk_sel) // R2
         cca_pkg::CCA_SRC_SYS_DIV_SLOW: tick = (st_r.slow_div == SLOW_LAST);
         cca_pkg::CCA_SRC_SYS_DIV_FAST: tick = (st_r.fast_div == FAST_LAST);
         cca_pkg::CCA_SRC_TIMER0_OVF: tick = timer0_ovf;
         cca_pkg::CCA_SRC_EXT_COUNT: tick = st_r.eci_sync[1] && !st_r.eci_prev;
         cca_pkg::CCA_SRC_SYS: tick = 1'b1;
         cca_pkg::CCA_SRC_EXT_OSC: tick = st_r.osc_sync[1] && !st_r.osc_prev &&
                                          (st_r.osc_div == OSC_LAST);
         default: tick = 1'b0;
      endcase
      tick = tick && run && counter_run; // R7

      // time base
      cnt_inc = 16'(st_r.cnt + cca_pkg::CNT_ONE);
      if (tick) begin
         st_nxt.cnt = cnt_inc; // R8
         st_nxt.ovf = (cnt_inc == cca_pkg::CNT_RST); // R8
      end

      // modules sharing the one time base
      for (int m = 0; m < cca_pkg::NUM_MOD; m++) begin // R1
         if (!(m == cca_pkg::WD_MOD && st_r.wd_en) && run) begin // R4 R7
            hit = tick && (st_r.cnt == mod_cfg[m].cmp);
            case (mod_cfg[m].mode) // R3
               cca_pkg::CCA_MODE_OFF: st_nxt.out[m] = 1'b0;
               cca_pkg::CCA_MODE_CAPTURE: begin
                  if (cca_edge(st_r.in_sync2[m], st_r.in_prev[m],
                               mod_cfg[m].cap_rise, mod_cfg[m].cap_fall)) begin
                     st_nxt.cap[m] = st_r.cnt;
                     st_nxt.evt[m] = 1'b1;
                  end
               end
               cca_pkg::CCA_MODE_TIMER: st_nxt.evt[m] = hit;
               cca_pkg::CCA_MODE_HSO: begin
                  st_nxt.evt[m] = hit;
                  if (hit) begin
                     st_nxt.out[m] = !st_r.out[m];
                  end
               end
               cca_pkg::CCA_MODE_PWM8: begin
                  st_nxt.out[m] = (st_r.cnt[cca_pkg::BYTE_W-1:0] <
                                   mod_cfg[m].cmp[cca_pkg::BYTE_W-1:0]);
                  st_nxt.evt[m] = tick && (st_r.cnt[cca_pkg::BYTE_W-1:0] ==
                                           mod_cfg[m].cmp[cca_pkg::BYTE_W-1:0]);
               end
               cca_pkg::CCA_MODE_PWM16: begin
                  st_nxt.out[m] = (st_r.cnt < mod_cfg[m].cmp);
                  st_nxt.evt[m] = hit;
               end
               cca_pkg::CCA_MODE_FREQ: begin
                  // toggle each time the low byte meets the moving phase
                  if (tick && st_r.cnt[cca_pkg::BYTE_W-1:0] == st_r.phase[m]) begin
                     st_nxt.out[m] = !st_r.out[m];
                     st_nxt.evt[m] = 1'b1;
                     st_nxt.phase[m] = 8'(st_r.phase[m] +
                                          mod_cfg[m].cmp[cca_pkg::CNT_W-1:cca_pkg::BYTE_W]);
                  end
               end
               default: st_nxt.out[m] = 1'b0;
            endcase
         end
      end

      // watchdog on module 2
      if (wd_enable) begin
         st_nxt.wd_en = 1'b1; // R4
      end
      if (wd_disable) begin
         st_nxt.wd_en = 1'b0; // R4
      end
      if (st_r.wd_en) begin
         st_nxt.out[cca_pkg::WD_MOD] = 1'b0;
         if (wd_kick) begin
            st_nxt.wd_cmp = 16'(st_r.cnt + wd_offset); // R4
         end
         if (tick && st_r.cnt == st_r.wd_cmp) begin
            st_nxt.wd_rst = 1'b1; // R4
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.cnt <= cca_pkg::CNT_RST;
         st_r.slow_div <= cca_pkg::DIV_RST;
         st_r.fast_div <= cca_pkg::DIV_RST;
         st_r.osc_div <= cca_pkg::DIV_RST;
         st_r.wd_en <= 1'b1; // R5
         st_r.wd_cmp <= cca_pkg::WD_CMP_RST; // R5
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs toward the crossbar and core
   // ------------------------------------------------------------
   assign count = st_r.cnt;
   assign mod_out = st_r.out; // R6
   assign cap_val = st_r.cap;
   assign mod_evt = st_r.evt;
   assign cnt_ovf = st_r.ovf;
   assign wd_active = st_r.wd_en;
   assign wd_reset = st_r.wd_rst;

endmodule : cca_counter_array

// ### cca_counter_array_assertions.sv
// port timing checks for the counter array
// assumes: bound into cca_counter_array, one clock, rst async high
`timescale 1ns/1ps
module cca_counter_array_chk (
   input wire logic core_clk, // system clock
   input wire logic rst, // async reset
   input wire logic counter_run, // time base enable
   input wire cca_pkg::cca_clksrc_e clk_sel, // source
   input wire logic debug_halt, // core halted
   input wire cca_pkg::cca_mod_cfg_s [cca_pkg::NUM_MOD-1:0] mod_cfg, // setup
   input wire logic wd_disable, // leave watchdog
   input wire logic wd_enable, // enter watchdog
   input wire logic [cca_pkg::CNT_W-1:0] count, // time base
   input wire logic [cca_pkg::NUM_MOD-1:0] mod_out, // pin outputs
   input wire logic [cca_pkg::NUM_MOD-1:0] mod_evt, // events
   input wire logic cnt_ovf, // wrap pulse
   input wire logic wd_active, // watchdog on
   input wire logic wd_reset // expiry pulse
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic tick = counter_run && clk_sel == cca_pkg::CCA_SRC_SYS && !debug_halt;
   AST_CNT_STEP: assert property (tick && !$past(rst) |=> count == $past(count) + 16'h0001)
      else $error("count did not step");
   AST_WRAP: assert property (tick && count == 16'hFFFF |=> count == 16'h0000 ##[0:1] cnt_ovf)
      else $error("no wrap");
   AST_HALT_FREEZE: assert property (debug_halt |=> $stable(count))
      else $error("count moved in halt");
   AST_HALT_QUIET: assert property (debug_halt |=> mod_evt == 3'h0 && !wd_reset)
      else $error("pulse in halt");
   AST_TIMER_MATCH: assert property (tick && !$past(rst) && mod_cfg[0].mode ==
      cca_pkg::CCA_MODE_TIMER && count == mod_cfg[0].cmp |=> mod_evt[0]) else $error("no match");
   AST_OFF_QUIET: assert property ((mod_cfg[1].mode == cca_pkg::CCA_MODE_OFF) [*2] |-> !mod_evt[1])
      else $error("event while off");
   AST_RESET_WD: assert property ($fell(rst) |-> wd_active && count == 16'h0000)
      else $error("bad reset state");
   AST_WD_OFF: assert property (wd_disable |=> !wd_active)
      else $error("watchdog stayed on");
   AST_WD_ON: assert property (wd_enable && !wd_disable |=> wd_active)
      else $error("watchdog stayed off");
   AST_WD_PIN: assert property (wd_active [*3] |-> !mod_out[2])
      else $error("pin driven in watchdog");
endmodule : cca_counter_array_chk
bind cca_counter_array cca_counter_array_chk u_chk (.core_clk, .rst, .counter_run, .clk_sel,
   .debug_halt, .mod_cfg, .wd_disable, .wd_enable, .count, .mod_out, .mod_evt, .cnt_ovf,
   .wd_active, .wd_reset);

// ### cca_pin_model.sv
// pads and oscillator beyond the crossbar
// assumes: bench asks for pin levels; oscillator idles low when off
`timescale 1ns/1ps
module cca_pin_model (
   input wire logic [3:0] lvl_req, // pin levels, bit 3 count pin
   input wire logic osc_en, // oscillator on
   output logic ext_count_input, // count pin
   output logic ext_osc_clk, // oscillator
   output logic [2:0] mod_in // module pins
);
   // off the clock grid, like a real pad
   assign #1.3 {ext_count_input, mod_in} = lvl_req;
   initial ext_osc_clk = 1'b0;
   always begin
      #11;
      ext_osc_clk = osc_en ? !ext_osc_clk : 1'b0;
   end
endmodule : cca_pin_model

// ### cca_pkg.sv
// cca_pkg: shared types and constants of the counter array capture/compare block
// assumes: used with cca_counter_array on one 250 MHz core clock
package cca_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int NUM_MOD = 3;
   localparam int WD_MOD = 2;
   localparam int BYTE_W = 8;

   // ------------------------------------------------------------
   // time base sources
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CCA_SRC_SYS_DIV_SLOW = 3'h0,
      CCA_SRC_SYS_DIV_FAST = 3'h1,
      CCA_SRC_TIMER0_OVF = 3'h2,
      CCA_SRC_EXT_COUNT = 3'h3,
      CCA_SRC_SYS = 3'h4,
      CCA_SRC_EXT_OSC = 3'h5
   } cca_clksrc_e;

   // ------------------------------------------------------------
   // module modes, one-hot
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      CCA_MODE_OFF = 7'h01,
      CCA_MODE_CAPTURE = 7'h02,
      CCA_MODE_TIMER = 7'h04,
      CCA_MODE_HSO = 7'h08,
      CCA_MODE_PWM8 = 7'h10,
      CCA_MODE_PWM16 = 7'h20,
      CCA_MODE_FREQ = 7'h40
   } cca_mode_e;

   // ------------------------------------------------------------
   // per-module configuration
   // ------------------------------------------------------------
   typedef struct packed {
      cca_mode_e mode;
      logic cap_rise;
      logic cap_fall;
      logic [CNT_W-1:0] cmp;
   } cca_mod_cfg_s;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] WD_CMP_RST = 16'hFFFF;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] DIV_RST = 4'h0;
   localparam logic [3:0] DIV_ONE = 4'h1;

endpackage : cca_pkg

// ### test_counter_array_capture_compare.sv
// self-checking bench of the counter array
// assumes: cca_pin_model as pads, checker bound in
`timescale 1ns/1ps
module test_counter_array_capture_compare;
   typedef struct {int idx; logic [15:0] val; bit cap;} cca_note_s;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic counter_run = 1'b0;
   cca_pkg::cca_clksrc_e clk_sel = cca_pkg::CCA_SRC_SYS;
   logic timer0_ovf = 1'b0;
   logic debug_halt = 1'b0;
   cca_pkg::cca_mod_cfg_s [2:0] mod_cfg;
   logic wd_kick = 1'b0;
   logic wd_disable = 1'b0;
   logic wd_enable = 1'b0;
   logic [15:0] wd_offset = 16'h0000;
   logic [3:0] lvl_req = 4'h0;
   logic osc_en = 1'b0;
   wire logic ext_count_input, ext_osc_clk;
   wire logic [2:0] mod_in;
   logic [15:0] count, c, e;
   logic [2:0] mod_out, mod_evt;
   logic [2:0][15:0] cap_val;
   logic cnt_ovf, wd_active, wd_reset;
   wire logic [3:0] ev = {wd_reset, mod_evt};
   int failures = 0, total_checks = 0, cyc = 0, k, s, d, x;
   int rate[7] = '{8, 24, 0, 12, 96, 2, 0};
   logic [31:0] seed = 32'h0001454F;
   cca_note_s q[$];
   cca_note_s n;
   cca_counter_array u_dut (.core_clk, .rst, .counter_run, .clk_sel, .timer0_ovf, .ext_count_input,
      .ext_osc_clk, .debug_halt, .mod_cfg, .mod_in, .wd_kick, .wd_disable, .wd_enable, .wd_offset,
      .count, .mod_out, .cap_val, .mod_evt, .cnt_ovf, .wd_active, .wd_reset);
   cca_pin_model u_pins (.lvl_req, .osc_en, .ext_count_input, .ext_osc_clk, .mod_in);
   initial forever #2 core_clk = ~core_clk;
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction : rnd
   task automatic tk(input int t);
      repeat (t) @(posedge core_clk);
      #1;
   endtask : tk
   task automatic chk(input bit ok, input string m);
      total_checks++;
      if (!ok) begin
         failures++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask : chk
   task automatic end_sim();
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic freeze();
      counter_run = 1'b0;
      tk(2);
   endtask : freeze
   task automatic arm(input int m, input cca_pkg::cca_mode_e md, input int t);
      freeze();
      mod_cfg[m].mode = md;
      mod_cfg[m].cmp = count + 16'(t);
      q.push_back('{m, count + 16'(t + 1), 1'b0});
      counter_run = 1'b1;
      tk(t + 6);
      mod_cfg[m].mode = cca_pkg::CCA_MODE_OFF;
   endtask : arm
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         end_sim();
      end
   end
   // ----
   // result watcher
   // ----
   always @(negedge core_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (!rst && ev[i] === 1'b1) begin
            if (q.size() == 0) chk(1'b0, "event without note");
            else begin
               n = q.pop_front();
               chk(n.idx == i && (n.cap ? cap_val[i] : count) === n.val, "event value");
            end
         end
      end
   end
   // ----
   // scenarios
   // ----
   initial begin
      foreach (mod_cfg[m]) mod_cfg[m] = '{cca_pkg::CCA_MODE_OFF, 1'b0, 1'b0, 16'h0000};
      tk(5);
      rst = 1'b0;
      chk(wd_active === 1'b1 && count === 16'h0000, "reset state");
      c = rnd() & 16'h7FFF | 16'h0100;
      mod_cfg[0].mode = cca_pkg::CCA_MODE_TIMER;
      mod_cfg[0].cmp = c;
      q.push_back('{0, c + 16'h0001, 1'b0});
      q.push_back('{3, 16'h0000, 1'b0});
      counter_run = 1'b1;
      for (k = 0; k < 70000 && cnt_ovf !== 1'b1; k++) @(negedge core_clk);
      chk(count < 16'h0004, "wrap");
      tk(1);
      mod_cfg[0].mode = cca_pkg::CCA_MODE_OFF;
      freeze();
      e = rnd() & 16'h00FF | 16'h0010;
      wd_offset = e;
      wd_kick = 1'b1;
      q.push_back('{3, count + e + 16'h0001, 1'b0});
      tk(1);
      wd_kick = 1'b0;
      counter_run = 1'b1;
      tk(300);
      wd_disable = 1'b1;
      tk(1);
      wd_disable = 1'b0;
      tk(1);
      chk(wd_active === 1'b0, "watchdog off");
      arm(1, cca_pkg::CCA_MODE_TIMER, 40);
      arm(1, cca_pkg::CCA_MODE_HSO, 25);
      arm(2, cca_pkg::CCA_MODE_TIMER, 33);
      freeze();
      mod_cfg[1].cmp = 16'h0000;
      mod_cfg[1].mode = cca_pkg::CCA_MODE_FREQ;
      e = count[7:0] == 8'h00 ? count + 16'h0001 : (count | 16'h00FF) + 16'h0002;
      q.push_back('{1, e, 1'b0});
      counter_run = 1'b1;
      for (k = 0; k < 300 && mod_evt[1] !== 1'b1; k++) @(negedge core_clk);
      tk(1);
      freeze();
      for (k = 0; k < 6; k++) begin
         c = rnd();
         mod_cfg[1].cmp = c;
         mod_cfg[1].mode = k[0] ? cca_pkg::CCA_MODE_PWM8 : cca_pkg::CCA_MODE_PWM16;
         tk(4);
         chk(mod_out[1] === (k[0] ? count[7:0] < c[7:0] : count < c), "pwm level");
      end
      mod_cfg[1].mode = cca_pkg::CCA_MODE_CAPTURE;
      for (k = 0; k < 4; k++) begin
         mod_cfg[1].cap_rise = k < 2;
         mod_cfg[1].cap_fall = k > 1;
         if (k == 0 || k == 3) q.push_back('{1, count, 1'b1});
         lvl_req[1] = !k[0];
         tk(8);
      end
      mod_cfg[1].mode = cca_pkg::CCA_MODE_OFF;
      for (s = 0; s < 7; s++) begin
         freeze();
         c = count;
         clk_sel = cca_pkg::cca_clksrc_e'(s[2:0]);
         counter_run = 1'b1;
         osc_en = s == 5;
         d = 0;
         for (k = 0; k < 96; k++) begin
            timer0_ovf = rnd() > 16'h7FFF;
            d += timer0_ovf;
            lvl_req[3] = k[2];
            tk(1);
         end
         counter_run = 1'b0;
         osc_en = 1'b0;
         timer0_ovf = 1'b0;
         tk(4);
         x = count - c;
         e = 16'(s == 2 ? d : rate[s]);
         chk(!$isunknown(count) && x + 1 >= e && x <= e + 1, "source rate");
      end
      clk_sel = cca_pkg::CCA_SRC_SYS;
      counter_run = 1'b1;
      debug_halt = 1'b1;
      tk(2);
      c = count;
      tk(20);
      chk(count === c, "halt");
      debug_halt = 1'b0;
      wd_enable = 1'b1;
      tk(1);
      wd_enable = 1'b0;
      tk(4);
      chk(count !== c && wd_active === 1'b1 && mod_out[2] === 1'b0, "resume");
      rst = 1'b1;
      tk(2);
      rst = 1'b0;
      chk(count === 16'h0000 && wd_active === 1'b1, "second reset");
      tk(10);
      chk(q.size() == 0, "notes left");
      end_sim();
   end
endmodule : test_counter_array_capture_compare
